// ---- rtl/sadc_regs.svh ----
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define SADC_IDX_SC1        6'h30
`define SADC_IDX_SC2        6'h31
`define SADC_IDX_RH         6'h32
`define SADC_IDX_RL         6'h33
`define SADC_IDX_CVH        6'h34
`define SADC_IDX_CVL        6'h35
`define SADC_IDX_CFG        6'h36
`define SADC_ADDR_W         8
`define SADC_WORD_LSB       2

// ------------------------------------------------------------
// reset values and field codes
// ------------------------------------------------------------
`define SADC_SC1_RST        8'h1F
`define SADC_SC2_RST        8'h00
`define SADC_CH_OFF         5'h1F
`define SADC_CLK_BUS        2'h0
`define SADC_CLK_HALF       2'h1
`define SADC_CLK_ALT        2'h2
`define SADC_CLK_ASYNC      2'h3
`define SADC_MODE_8         2'h0
`define SADC_MODE_10        2'h1
`define SADC_MSB_8          4'h7
`define SADC_MSB_10         4'h9
`define SADC_MSB_12         4'hB
`define SADC_SAMPLE_TICKS   2'h2
`define SADC_RESP_OKAY      2'h0
`define SADC_RESP_SLVERR    2'h2

`endif

// ---- rtl/sadc_pkg.sv ----
package sadc_pkg;

    // ------------------------------------------------------------
    // register layouts
    // ------------------------------------------------------------
    typedef struct packed {
        logic       done_irq_enable;
        logic       continuous_select;
        logic [4:0] channel_select;
    } sadc_sc1_s;

    typedef struct packed {
        logic       hw_trigger_select;
        logic       compare_enable;
        logic       compare_direction;
        logic [1:0] reference_select;
    } sadc_sc2_s;

    typedef struct packed {
        logic       low_power;
        logic [1:0] clock_divider;
        logic       long_sample;
        logic [1:0] mode;
        logic [1:0] clock_source_select;
    } sadc_cfg_s;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} sadc_state_e;

endpackage

// ---- rtl/sadc_top.sv ----
`timescale 1ns/1ps
`include "sadc_regs.svh"
module sadc_top
    import sadc_pkg::*;
(
    input  wire logic                    aclk,             // bus clock, 25 MHz
    input  wire logic                    aresetn,          // synchronous reset, low active
    input  wire logic [`SADC_ADDR_W-1:0] s_axi_awaddr,     // write address
    input  wire logic                    s_axi_awvalid,    // write address valid
    output logic                         s_axi_awready,    // write address ready
    input  wire logic [31:0]             s_axi_wdata,      // write data
    input  wire logic [3:0]              s_axi_wstrb,      // write byte enables
    input  wire logic                    s_axi_wvalid,     // write data valid
    output logic                         s_axi_wready,     // write data ready
    output logic [1:0]                   s_axi_bresp,      // write response
    output logic                         s_axi_bvalid,     // write response valid
    input  wire logic                    s_axi_bready,     // write response ready
    input  wire logic [`SADC_ADDR_W-1:0] s_axi_araddr,     // read address
    input  wire logic                    s_axi_arvalid,    // read address valid
    output logic                         s_axi_arready,    // read address ready
    output logic [31:0]                  s_axi_rdata,      // read data
    output logic [1:0]                   s_axi_rresp,      // read response
    output logic                         s_axi_rvalid,     // read data valid
    input  wire logic                    s_axi_rready,     // read data ready
    input  wire logic                    alternate_clock,  // alternate clock tick
    input  wire logic                    internal_async_clock, // internal clock tick
    input  wire logic                    hw_trigger,       // hardware trigger pulse
    input  wire logic                    stop_mode,        // system in stop mode
    input  wire logic                    comp_in,          // analog >= trial code
    output logic [4:0]                   channel_out,      // analog multiplexer select
    output logic [1:0]                   ref_select_out,   // reference source select
    output logic                         sample_out,       // sample switch closed
    output logic [11:0]                  trial_code,       // code to the SAR DAC
    output logic                         done_irq,         // interrupt request level
    output logic                         wake_req          // stop wake-up pulse
);
    import sadc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    sadc_sc1_s   sc1_reg;
    sadc_sc2_s   sc2_reg;
    sadc_cfg_s   cfg_reg;
    sadc_state_e state_reg;
    logic        coco_reg;
    logic [11:0] result_reg;
    logic [11:0] cmpval_reg;
    logic [11:0] sar_reg;
    logic [3:0]  bit_reg;
    logic [1:0]  smp_reg;
    logic        half_reg;
    logic [2:0]  div_reg;
    logic [`SADC_ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        aw_held;
    logic        w_held;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic       do_write;
    logic       do_read;
    logic [5:0] wword;
    logic [5:0] rword;
    logic       wr_lane;
    logic       sc1_wr;
    logic       rl_rd;

    // write proceeds once both address and data are held
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign do_read  = s_axi_arvalid && s_axi_arready;
    assign wword    = awaddr_reg[`SADC_ADDR_W-1:`SADC_WORD_LSB];
    assign rword    = s_axi_araddr[`SADC_ADDR_W-1:`SADC_WORD_LSB];
    assign wr_lane  = do_write && wstrb_reg[0];
    assign sc1_wr   = wr_lane && (wword == `SADC_IDX_SC1);
    assign rl_rd    = do_read && (rword == `SADC_IDX_RL);

    // ------------------------------------------------------------
    // conversion clock: source select, stop gating, divider
    // ------------------------------------------------------------
    logic       src_tick;
    logic       run_ok;
    logic [2:0] div_mask;
    logic       tick;

    // pick one of four sources as an enable
    always_comb
    begin
        unique case (cfg_reg.clock_source_select)
            `SADC_CLK_BUS:  src_tick = 1'b1;
            `SADC_CLK_HALF: src_tick = half_reg;
            `SADC_CLK_ALT:  src_tick = alternate_clock;
            default:        src_tick = internal_async_clock;
        endcase
    end

    // only the internal clock keeps running in stop mode
    assign run_ok   = !stop_mode || (cfg_reg.clock_source_select == `SADC_CLK_ASYNC);
    assign div_mask = 3'(({1'b0, 3'h1} << cfg_reg.clock_divider) - 4'h1);
    assign tick     = src_tick && run_ok && ((div_reg & div_mask) == div_mask);

    // half-rate toggle for the halved bus clock
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            half_reg <= 1'b0;
        else
            half_reg <= !half_reg;
    end

    // divider counts source ticks
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            div_reg <= 3'h0;
        else if (src_tick && run_ok)
            div_reg <= div_reg + 3'h1;
    end

    // ------------------------------------------------------------
    // successive approximation
    // ------------------------------------------------------------
    logic [3:0]  msb;
    logic [11:0] bit_oh;
    logic [11:0] decided;
    logic        finish;
    logic        cmp_ok;
    logic        start;
    logic        ch_on;
    logic        wr_ch_on;

    // top bit index per resolution
    always_comb
    begin
        unique case (cfg_reg.mode)
            `SADC_MODE_8:  msb = `SADC_MSB_8;
            `SADC_MODE_10: msb = `SADC_MSB_10;
            default:       msb = `SADC_MSB_12;
        endcase
    end

    assign bit_oh   = 12'h001 << bit_reg;
    assign decided  = comp_in ? sar_reg : (sar_reg & ~bit_oh);
    assign finish   = (state_reg == ST_CONVERT) && tick && (bit_reg == 4'h0);
    // compare on the finished code
    assign cmp_ok   = !sc2_reg.compare_enable ||
                      (sc2_reg.compare_direction ? (decided >= cmpval_reg)
                                                 : (decided <  cmpval_reg));
    assign ch_on    = sc1_reg.channel_select != `SADC_CH_OFF;
    assign wr_ch_on = wdata_reg[4:0] != `SADC_CH_OFF;
    // software start on write, hardware start on trigger, continuous restart
    assign start    = (sc1_wr && wr_ch_on && !sc2_reg.hw_trigger_select)
                   || (!sc1_wr && ch_on && sc2_reg.hw_trigger_select && hw_trigger
                       && (state_reg == ST_IDLE))
                   || (!sc1_wr && finish && ch_on && sc1_reg.continuous_select);

    // conversion sequencer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_reg <= ST_IDLE;
        else if (start)
            state_reg <= ST_SAMPLE;
        else if (sc1_wr || finish)
            state_reg <= ST_IDLE;
        else if (state_reg == ST_SAMPLE && tick && smp_reg == 2'h0)
            state_reg <= ST_CONVERT;
    end

    // sample counter and bit walk; trial code moves with sar so the comparator never sees a stale trial
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            smp_reg    <= 2'h0;
            bit_reg    <= 4'h0;
            sar_reg    <= 12'h000;
            trial_code <= 12'h000;
        end
        else if (start)
        begin
            smp_reg    <= `SADC_SAMPLE_TICKS - 2'h1;
            bit_reg    <= msb;
            sar_reg    <= 12'h001 << msb;
            trial_code <= 12'h001 << msb;
        end
        else if (state_reg == ST_SAMPLE && tick)
            smp_reg <= smp_reg - ((smp_reg == 2'h0) ? 2'h0 : 2'h1);
        else if (state_reg == ST_CONVERT && tick && bit_reg != 4'h0)
        begin
            sar_reg    <= decided | (bit_oh >> 1);
            trial_code <= decided | (bit_oh >> 1);
            bit_reg    <= bit_reg - 4'h1;
        end
    end

    // result and flag only on a passing conversion
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            result_reg <= 12'h000;
        else if (finish && cmp_ok)
            result_reg <= decided;
    end

    // complete flag: set wins over clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            coco_reg <= 1'b0;
        else if (finish && cmp_ok)
            coco_reg <= 1'b1;
        else if (rl_rd || sc1_wr)
            coco_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // registers written by software
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sc1_reg    <= sadc_sc1_s'(`SADC_SC1_RST);
            sc2_reg    <= sadc_sc2_s'(`SADC_SC2_RST);
            cfg_reg    <= '0;
            cmpval_reg <= 12'h000;
        end
        else if (wr_lane)
        begin
            unique case (wword)
                `SADC_IDX_SC1: sc1_reg <= sadc_sc1_s'(wdata_reg[6:0]);
                `SADC_IDX_SC2: sc2_reg <= {wdata_reg[6:4], wdata_reg[1:0]};
                `SADC_IDX_CVH: cmpval_reg[11:8] <= wdata_reg[3:0];
                `SADC_IDX_CVL: cmpval_reg[7:0]  <= wdata_reg[7:0];
                `SADC_IDX_CFG: cfg_reg <= sadc_cfg_s'(wdata_reg[7:0]);
                default:       cmpval_reg <= cmpval_reg;
            endcase
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            awaddr_reg    <= '0;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SADC_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !do_write;
            s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !do_write;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held    <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held    <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wword >= `SADC_IDX_SC1 && wword <= `SADC_IDX_CFG)
                                ? `SADC_RESP_OKAY : `SADC_RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    logic [7:0] rbyte;
    logic       rmapped;

    // read mux
    always_comb
    begin
        rmapped = 1'b1;
        unique case (rword)
            `SADC_IDX_SC1: rbyte = {coco_reg, sc1_reg};
            `SADC_IDX_SC2: rbyte = {state_reg != ST_IDLE, sc2_reg[4:2], 2'h0,
                                    sc2_reg.reference_select};
            `SADC_IDX_RH:  rbyte = {4'h0, result_reg[11:8]};
            `SADC_IDX_RL:  rbyte = result_reg[7:0];
            `SADC_IDX_CVH: rbyte = {4'h0, cmpval_reg[11:8]};
            `SADC_IDX_CVL: rbyte = cmpval_reg[7:0];
            `SADC_IDX_CFG: rbyte = cfg_reg;
            default:
            begin
                rbyte   = 8'h00;
                rmapped = 1'b0;
            end
        endcase
    end

    // read answers one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `SADC_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !do_read;
            if (do_read)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h00_0000, rbyte};
                s_axi_rresp  <= rmapped ? `SADC_RESP_OKAY : `SADC_RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // analog side and system outputs
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            channel_out    <= `SADC_CH_OFF;
            ref_select_out <= 2'h0;
            sample_out     <= 1'b0;
            done_irq       <= 1'b0;
            wake_req       <= 1'b0;
        end
        else
        begin
            channel_out    <= sc1_reg.channel_select;
            ref_select_out <= sc2_reg.reference_select;
            sample_out     <= state_reg == ST_SAMPLE;
            done_irq       <= coco_reg && sc1_reg.done_irq_enable;
            wake_req       <= finish && cmp_ok && stop_mode;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    coco_sets_a: assert property (finish && cmp_ok |=> coco_reg) else $error("flag not set");
    cmp_fail_keep_a: assert property (finish && !cmp_ok |=> $stable(result_reg))
        else $error("result changed on failed compare");
    irq_follow_a: assert property (coco_reg && sc1_reg.done_irq_enable |=> done_irq)
        else $error("interrupt missing");
    chan_off_idle_a: assert property (!ch_on |-> state_reg == ST_IDLE)
        else $error("converter running while disabled");
    stop_freeze_a: assert property (!run_ok && !start && !sc1_wr
        |=> $stable(sar_reg) && $stable(state_reg)) else $error("conversion moved in stop");
    wake_cause_a: assert property (wake_req |-> $past(finish && cmp_ok && stop_mode))
        else $error("wake without passing conversion");
    sw_no_hw_a: assert property (hw_trigger && !sc2_reg.hw_trigger_select && !sc1_wr
        && state_reg == ST_IDLE |=> state_reg == ST_IDLE) else $error("hardware trigger in software mode");
    cont_restart_a: assert property (finish && ch_on && sc1_reg.continuous_select && !sc1_wr
        |=> state_reg == ST_SAMPLE ##1 sample_out) else $error("continuous restart missing");
    rl_clear_a: assert property (rl_rd && !(finish && cmp_ok) |=> !coco_reg)
        else $error("flag not cleared by result read");
    div_eight_a: assert property (tick && cfg_reg.clock_divider == 2'h3 && !stop_mode
        && cfg_reg.clock_source_select == `SADC_CLK_BUS && !wr_lane |=> !tick [*7])
        else $error("divide by eight too fast");

    single_cover_c: cover property (start ##[1:60] finish && cmp_ok);
    cmp_fail_c: cover property (finish && sc2_reg.compare_enable && !cmp_ok);
    abort_c: cover property (state_reg == ST_CONVERT && sc1_wr);
    stop_wake_c: cover property (wake_req);

endmodule

// ---- sim/sadc_sar_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// analog front end: sample and hold plus comparator
// ------------------------------------------------------------
module sadc_sar_model (
    input  wire logic        aclk,       // bus clock
    input  wire logic        sample_out, // sample switch closed
    input  wire logic [11:0] trial_code, // code from the sar dac
    input  wire logic [11:0] level,      // input level in result units
    output logic             comp_in     // high when held level >= trial code
);
    logic [11:0] held = 12'h000; // level frozen at the end of sampling

    // track the input only while the switch is closed
    always @(posedge aclk)
        if (sample_out)
            held <= level;

    // comparator decision on the held level
    assign comp_in = (held >= trial_code);
endmodule

// ---- sim/sar_adc_control_tb_top.sv ----
`timescale 1ns/1ps
`include "sadc_regs.svh"
module sar_adc_control_tb_top;
    import sadc_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        alternate_clock, internal_async_clock, hw_trigger, stop_mode, comp_in;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        sample_out, done_irq, wake_req;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, v;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, ref_select_out, rs, wrs;
    logic [4:0]  channel_out, ch;
    logic [11:0] trial_code, level;
    logic [7:0]  rv [7] = '{`SADC_SC1_RST, `SADC_SC2_RST, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    int          failures, tests_run, cyc, wakes, lvl, exp_q[$];

    sadc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .alternate_clock(alternate_clock), .internal_async_clock(internal_async_clock),
        .hw_trigger(hw_trigger), .stop_mode(stop_mode), .comp_in(comp_in), .channel_out(channel_out),
        .ref_select_out(ref_select_out), .sample_out(sample_out), .trial_code(trial_code),
        .done_irq(done_irq), .wake_req(wake_req));
    sadc_sar_model far (.aclk(aclk), .sample_out(sample_out), .trial_code(trial_code), .level(level),
                        .comp_in(comp_in));

    // ------------------------------------------------------------
    // clock, random source ticks and watchdog
    // ------------------------------------------------------------
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        alternate_clock <= 1'($urandom % 2);
        internal_async_clock <= 1'($urandom % 2);
        wakes <= wakes + int'(wake_req);
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            failures++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // bus tasks and checks
    // ------------------------------------------------------------
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        wrs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [5:0] idx, output logic [7:0] d, output logic [1:0] r);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata[7:0];
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_res();
        logic [7:0] h;
        rd(`SADC_IDX_RH, h, rs);
        rd(`SADC_IDX_RL, v, rs);
        chk("result", 12'(exp_q.pop_front()), {h[3:0], v});
    endtask
    task automatic wait_flag(input int lim);
        v = 8'h00;
        for (int i = 0; i < lim && v[7] !== 1'b1; i++)
            rd(`SADC_IDX_SC1, v, rs);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, hw_trigger, stop_mode} = '0;
        {alternate_clock, internal_async_clock, s_axi_awaddr, s_axi_araddr, s_axi_wdata, level} = '0;
        s_axi_wstrb = 4'hF;
        aresetn = 1'b0;
        lvl = $urandom(52);
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (rv[i])
        begin
            rd(6'h30 + 6'(i), v, rs);
            chk("reset value", rv[i], v);
        end
        rd(6'h3F, v, rs);
        chk("unmapped resp", `SADC_RESP_SLVERR, rs);
        wr(6'h3F, 8'h00);
        chk("unmapped write resp", `SADC_RESP_SLVERR, wrs);
        $display("test reset and map finished");
        for (int i = 0; i < 4; i++)
        begin
            lvl = $urandom % (i == 0 ? 256 : i == 1 ? 1024 : 4096);
            ch = 5'($urandom % 31);
            level <= lvl[11:0];
            exp_q.push_back(lvl);
            wr(`SADC_IDX_CFG, {1'b0, 2'(i), 1'b0, (i == 3) ? 2'h2 : 2'(i), 2'(i)});
            wr(`SADC_IDX_SC1, {3'h2, ch});
            rd(`SADC_IDX_SC2, v, rs);
            chk("active", 1, v[7]);
            wait_flag(200);
            chk("irq", 1, done_irq);
            chk("channel", ch, channel_out);
            chk_res();
            rd(`SADC_IDX_SC1, v, rs);
            chk("flag cleared", 0, v[7]);
        end
        $display("test single conversions finished");
        wr(`SADC_IDX_CFG, 8'h08);
        wr(`SADC_IDX_CVH, 8'h08);
        wr(`SADC_IDX_CVL, 8'h00);
        rd(`SADC_IDX_CVH, v, rs);
        chk("compare high", 8'h08, v);
        level <= 12'h400;
        exp_q.push_back(lvl);
        wr(`SADC_IDX_SC2, 8'h30);
        wr(`SADC_IDX_SC1, 8'h03);
        wait_flag(30);
        chk("failed compare flag", 0, v[7]);
        chk_res();
        exp_q.push_back(12'h400);
        wr(`SADC_IDX_SC2, 8'h20);
        wr(`SADC_IDX_SC1, 8'h03);
        wait_flag(30);
        chk("passed compare flag", 1, v[7]);
        chk_res();
        $display("test compare finished");
        wr(`SADC_IDX_CFG, 8'h08);
        wr(`SADC_IDX_SC2, 8'h30);
        stop_mode <= 1'b1;
        wr(`SADC_IDX_SC1, 8'h23);
        repeat (100) @(posedge aclk);
        rd(`SADC_IDX_SC2, v, rs);
        chk("frozen active", 8'hB0, v);
        wr(`SADC_IDX_CFG, 8'h0B);
        repeat (150) @(posedge aclk);
        chk("early wake", 0, 12'(wakes));
        level <= 12'h900;
        for (int i = 0; i < 300 && wakes == 0; i++)
            @(posedge aclk);
        chk("wake", 1, wakes > 0);
        stop_mode <= 1'b0;
        wr(`SADC_IDX_SC1, 8'h1F);
        $display("test stop wake finished");
        lvl = $urandom % 256;
        level <= lvl[11:0];
        wr(`SADC_IDX_SC2, 8'h00);
        wr(`SADC_IDX_CFG, 8'h00);
        wr(`SADC_IDX_SC1, 8'h25);
        repeat (2)
        begin
            exp_q.push_back(lvl);
            wait_flag(30);
            chk("continuous flag", 1, v[7]);
            chk_res();
        end
        wr(`SADC_IDX_SC1, 8'h1F);
        $display("test continuous finished");
        exp_q.push_back(lvl);
        wr(`SADC_IDX_SC2, 8'h40);
        wr(`SADC_IDX_SC1, 8'h04);
        rd(`SADC_IDX_SC2, v, rs);
        chk("no soft start", 8'h40, v);
        hw_trigger <= 1'b1;
        @(posedge aclk);
        hw_trigger <= 1'b0;
        wait_flag(30);
        chk_res();
        wr(`SADC_IDX_SC2, 8'h00);
        wr(`SADC_IDX_SC1, 8'h05);
        wr(`SADC_IDX_SC1, 8'h1F);
        rd(`SADC_IDX_SC2, v, rs);
        chk("aborted", 0, v[7]);
        wait_flag(20);
        chk("no flag", 0, v[7]);
        for (int r = 0; r < 4; r++)
        begin
            wr(`SADC_IDX_SC2, 8'(r));
            rd(`SADC_IDX_SC2, v, rs);
            chk("reference", 12'(r), ref_select_out);
        end
        $display("test trigger abort reference finished");
        complete_run();
    end
endmodule
